// ==== src/ext_stack_exec.sv ====
// decode and execute of the extended stack-frame instructions
`timescale 1ns/1ps
// Operation
// - call via working register pushes pc+2, loads pc from latches and w, nop cycle.
// - move-to-file source address is frame pointer plus 7-bit first-word offset.
// - move-to-file destination is the 12-bit absolute field of word two.
// - both move addresses reach the whole 4096-byte space, wrapping at 12 bits.
// - a source address on an indirect-access register yields zero data.
// - indexed-to-indexed with indirect destination writes nothing, acts as no-op.
// - indexed-to-indexed adds a separate 7-bit offset per word to frame pointer.
// - move opcode is 1110 1011, bit 7 picks indexed form; word two starts 1111.
// - push literal writes at frame pointer, then frame pointer decrements by one.
// - push literal is one word, one cycle, upper byte 1111 1010.
// - subtract 6-bit literal from selected pointer 0..2 in one cycle, opcode 1110 1001.
// - subtract-and-return lowers frame pointer then loads pc from stack top.
// - subtract-and-return takes two cycles, the second a no-op.
// - select value 11 means the return variant, acting on the frame pointer only.
// - all of this starts only while the extended-set enable is one; a move's second word is taken regardless.
module ext_stack_exec
  import ext_stack_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic extendedSetEnable,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  output logic instrTaken,
  output logic busy,
  input wire logic [7:0] workingRegister,
  input wire logic [7:0] pcHighLatch,
  input wire logic [4:0] pcUpperLatch,
  input wire logic [PC_W-1:0] pcCurrent,
  input wire logic [PC_W-1:0] returnStackTop,
  input wire logic ptrLoad,
  input wire logic [1:0] ptrLoadSel,
  input wire addr_t ptrLoadValue,
  output addr_t [PTR_N-1:0] indirectPointerReg,
  output memRd_s memRd,
  input wire logic [7:0] memRdData,
  output memWr_s memWr,
  output pcCtl_s pcCtl,
  output stackCtl_s stackCtl,
  output logic cycleStrobe,
  output logic statusWrite
);
  // =====================================================================
  // instruction cycle divider: four clocks per instruction cycle
  logic [1:0] qPhase_q, qPhase_d;
  always_comb
  begin
    qPhase_d = (qPhase_q == Q_LAST) ? Q_FIRST : qPhase_q + Q_STEP;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      qPhase_q <= Q_FIRST;
    else
      qPhase_q <= qPhase_d;
  end
  assign cycleStrobe = (qPhase_q == Q_LAST);
  // =====================================================================
  // decode
  typedef enum logic [1:0] {IDLE, MOVE_WORD2, NOP_CYCLE} state_e;
  state_e state_q, state_d;
  logic isCallw, isMove, isPush, isSub, isReturn;
  always_comb
  begin
    isCallw = (instrWord == OP_CALL_VIA_WORKING_REGISTER);
    isMove = (instrWord[15:8] == OP_MOVE_HI);
    isPush = (instrWord[15:8] == OP_PUSH_HI);
    isSub = (instrWord[15:8] == OP_SUB_HI);
    isReturn = isSub && (instrWord[7:6] == SEL_RETURN);
  end
  // the unit only claims first words while the extended set is switched on; a move's second word is claimed regardless
  logic take, take2;
  assign take = cycleStrobe && instrValid && extendedSetEnable && (state_q == IDLE)
    && (isCallw || isMove || isPush || isSub);
  assign take2 = cycleStrobe && instrValid && (state_q == MOVE_WORD2);
  assign instrTaken = take || take2;
  assign busy = (state_q != IDLE);
  // no status path exists here at all
  assign statusWrite = 1'b0;
  // =====================================================================
  // address forming; 12-bit sums wrap so every address is reachable
  addr_t framePtr, srcAddr, destAddr;
  logic srcIndirect, destIndirect;
  logic moveIndexed_q, moveIndexed_d;
  assign framePtr = indirectPointerReg[SEL_FRAME];
  assign srcAddr = framePtr + {5'h00, instrWord[6:0]};
  always_comb
  begin
    if (moveIndexed_q)
      destAddr = framePtr + {5'h00, instrWord[6:0]};
    else
      destAddr = instrWord[ADDR_W-1:0];
  end
  indirect_detect srcDetect (.addr(memRd.addr), .hit(srcIndirect));
  indirect_detect destDetect (.addr(destAddr), .hit(destIndirect));
  // =====================================================================
  // sequence, pointers and outputs: next values
  addr_t [PTR_N-1:0] ptr_d;
  memRd_s memRd_d;
  memWr_s memWr_d;
  pcCtl_s pcCtl_d;
  stackCtl_s stackCtl_d;
  logic [7:0] srcData_q, srcData_d;
  logic rdPending_q, rdPending_d;
  always_comb
  begin
    state_d = state_q;
    ptr_d = indirectPointerReg;
    moveIndexed_d = moveIndexed_q;
    memRd_d = '{en: 1'b0, addr: memRd.addr};
    memWr_d = '{en: 1'b0, addr: memWr.addr, data: memWr.data};
    pcCtl_d = '{load: 1'b0, value: pcCtl.value};
    stackCtl_d = '{push: 1'b0, pop: 1'b0, value: stackCtl.value};
    srcData_d = srcData_q;
    rdPending_d = memRd.en;
    // read data lands one clock after the strobe; indirect sources read as zero
    if (rdPending_q)
      srcData_d = srcIndirect ? ZERO_BYTE : memRdData;
    if (ptrLoad)
      ptr_d[ptrLoadSel] = ptrLoadValue;
    case (state_q)
      IDLE:
      begin
        if (take)
        begin
          if (isCallw)
          begin
            stackCtl_d.push = 1'b1;
            stackCtl_d.value = pcCurrent + PC_STEP;
            pcCtl_d.load = 1'b1;
            pcCtl_d.value = {pcUpperLatch, pcHighLatch, workingRegister};
            state_d = NOP_CYCLE;
          end
          else if (isMove)
          begin
            memRd_d = '{en: 1'b1, addr: srcAddr};
            moveIndexed_d = instrWord[MOVE_SS_BIT];
            state_d = MOVE_WORD2;
          end
          else if (isPush)
          begin
            memWr_d = '{en: 1'b1, addr: framePtr, data: instrWord[7:0]};
            ptr_d[SEL_FRAME] = framePtr - PUSH_STEP;
          end
          else if (isReturn)
          begin
            ptr_d[SEL_FRAME] = framePtr - {6'h00, instrWord[5:0]};
            stackCtl_d.pop = 1'b1;
            pcCtl_d = '{load: 1'b1, value: returnStackTop};
            state_d = NOP_CYCLE;
          end
          else
          begin
            // write wins over a core pointer load landing in the same cycle
            ptr_d[instrWord[7:6]] = indirectPointerReg[instrWord[7:6]]
              - {6'h00, instrWord[5:0]};
          end
        end
      end
      MOVE_WORD2:
      begin
        if (take2)
        begin
          // a malformed second word or indirect indexed target stores nothing
          if (instrWord[15:12] == WORD2_TAG && !(moveIndexed_q && destIndirect))
            memWr_d = '{en: 1'b1, addr: destAddr, data: srcData_q};
          state_d = IDLE;
        end
      end
      NOP_CYCLE:
      begin
        // the fetched word of this cycle is discarded by the core
        if (cycleStrobe)
          state_d = IDLE;
      end
      default:
        state_d = IDLE;
    endcase
  end
  // =====================================================================
  // registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= IDLE;
      indirectPointerReg <= {PTR_N{PTR_RESET}};
      moveIndexed_q <= 1'b0;
      memRd <= '0;
      memWr <= '0;
      pcCtl <= '0;
      stackCtl <= '0;
      srcData_q <= ZERO_BYTE;
      rdPending_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      indirectPointerReg <= ptr_d;
      moveIndexed_q <= moveIndexed_d;
      memRd <= memRd_d;
      memWr <= memWr_d;
      pcCtl <= pcCtl_d;
      stackCtl <= stackCtl_d;
      srcData_q <= srcData_d;
      rdPending_q <= rdPending_d;
    end
  end
  // =====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_call_via_working_register_target: assert property (take && isCallw |=> pcCtl.load && stackCtl.push
      && stackCtl.value == $past(pcCurrent) + PC_STEP
      && pcCtl.value == {$past(pcUpperLatch), $past(pcHighLatch), $past(workingRegister)})
    else $error("call via w target wrong");
  a_move_source: assert property (take && isMove |=> memRd.en
      && memRd.addr == $past(framePtr) + {5'h00, $past(instrWord[6:0])})
    else $error("move source address wrong");
  a_file_dest: assert property (take2 && !moveIndexed_q && instrWord[15:12] == WORD2_TAG
      |=> memWr.en && memWr.addr == $past(instrWord[ADDR_W-1:0]))
    else $error("move destination wrong");
  a_source_zero: assert property (rdPending_q && srcIndirect |=> srcData_q == ZERO_BYTE)
    else $error("indirect source not zero");
  a_indexed_nop: assert property (take2 && moveIndexed_q && destIndirect |=> !memWr.en)
    else $error("indirect destination written");
  a_push_frame: assert property (take && isPush |=> memWr.en
      && memWr.addr == $past(framePtr) && framePtr == $past(framePtr) - PUSH_STEP)
    else $error("push literal wrong");
  a_return_two: assert property (take && isReturn |=> pcCtl.load && stackCtl.pop
      && busy ##1 (busy && !cycleStrobe)[*2] ##1 !pcCtl.load)
    else $error("subtract and return sequence wrong");
  a_return_frame: assert property (take && isReturn |=>
      framePtr == $past(framePtr) - {6'h00, $past(instrWord[5:0])})
    else $error("frame pointer not lowered");
  a_disabled_idle: assert property (!extendedSetEnable && state_q == IDLE |-> !instrTaken)
    else $error("extended op taken while disabled");
  a_no_flags: assert property (instrTaken |-> ##[0:4] !statusWrite)
    else $error("status flags touched");
endmodule // ext_stack_exec

// ==== src/ext_stack_pkg.sv ====
// shared constants, opcodes and carrier types of the extended stack instruction unit
package ext_stack_pkg;
  // =====================================================================
  // widths and timing
  localparam int ADDR_W = 12;
  localparam int PC_W = 21;
  localparam int PTR_N = 3;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] Q_FIRST = 2'h0;
  localparam logic [1:0] Q_STEP = 2'h1;
  // =====================================================================
  // opcode fields
  localparam logic [15:0] OP_CALL_VIA_WORKING_REGISTER = 16'h0014;
  localparam logic [7:0] OP_MOVE_HI = 8'hEB;
  localparam logic [7:0] OP_SUB_HI = 8'hE9;
  localparam logic [7:0] OP_PUSH_HI = 8'hFA;
  localparam logic [3:0] WORD2_TAG = 4'hF;
  localparam int MOVE_SS_BIT = 7;
  localparam logic [1:0] SEL_RETURN = 2'h3;
  localparam logic [1:0] SEL_FRAME = 2'h2;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [ADDR_W-1:0] PUSH_STEP = 12'h001;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
  // =====================================================================
  // indirect-access register windows, five addresses each (plain defaults)
  localparam logic [ADDR_W-1:0] IND_TOP0 = 12'hFEF;
  localparam logic [ADDR_W-1:0] IND_TOP1 = 12'hFE7;
  localparam logic [ADDR_W-1:0] IND_TOP2 = 12'hFDF;
  localparam logic [ADDR_W-1:0] IND_SPAN = 12'h004;
  // =====================================================================
  // carriers
  typedef logic [ADDR_W-1:0] addr_t;
  typedef struct packed {
    logic en;
    addr_t addr;
  } memRd_s;
  typedef struct packed {
    logic en;
    addr_t addr;
    logic [7:0] data;
  } memWr_s;
  typedef struct packed {
    logic load;
    logic [PC_W-1:0] value;
  } pcCtl_s;
  typedef struct packed {
    logic push;
    logic pop;
    logic [PC_W-1:0] value;
  } stackCtl_s;
endpackage

// ==== src/indirect_detect.sv ====
// flags a data address that falls on an indirect-access register
`timescale 1ns/1ps
module indirect_detect
  import ext_stack_pkg::*;
#(
  parameter addr_t TOP0 = IND_TOP0,
  parameter addr_t TOP1 = IND_TOP1,
  parameter addr_t TOP2 = IND_TOP2
)
(
  input wire addr_t addr,
  output logic hit
);
  // each window spans TOPn-IND_SPAN .. TOPn
  always_comb
  begin
    hit = ((addr <= TOP0) && (addr >= TOP0 - IND_SPAN))
       || ((addr <= TOP1) && (addr >= TOP1 - IND_SPAN))
       || ((addr <= TOP2) && (addr >= TOP2 - IND_SPAN));
  end
endmodule // indirect_detect

// ==== tb/tb.sv ====
// self-checking bench for the extended stack instruction unit
`timescale 1ns/1ps
module tb
  import ext_stack_pkg::*;
;
  // =====================================================================
  // stimulus and observation
  logic clk, arst_n, extendedSetEnable, instrValid, ptrLoad;
  logic [15:0] instrWord;
  logic [7:0] workingRegister, pcHighLatch, memRdData;
  logic [4:0] pcUpperLatch;
  logic [PC_W-1:0] pcCurrent, returnStackTop;
  logic [1:0] ptrLoadSel;
  addr_t ptrLoadValue;
  logic instrTaken, busy, cycleStrobe, statusWrite, cBusy, cTaken, statusBad;
  addr_t [PTR_N-1:0] indirectPointerReg, cPtr;
  memRd_s memRd, cRd;
  memWr_s memWr, cWr;
  pcCtl_s pcCtl, cPc;
  stackCtl_s stackCtl, cSt;
  int mismatches, n_tests;
  ext_stack_exec dut (.clk(clk), .arst_n(arst_n), .extendedSetEnable(extendedSetEnable),
    .instrValid(instrValid), .instrWord(instrWord), .instrTaken(instrTaken), .busy(busy),
    .workingRegister(workingRegister), .pcHighLatch(pcHighLatch), .pcUpperLatch(pcUpperLatch),
    .pcCurrent(pcCurrent), .returnStackTop(returnStackTop), .ptrLoad(ptrLoad),
    .ptrLoadSel(ptrLoadSel), .ptrLoadValue(ptrLoadValue),
    .indirectPointerReg(indirectPointerReg), .memRd(memRd), .memRdData(memRdData),
    .memWr(memWr), .pcCtl(pcCtl), .stackCtl(stackCtl), .cycleStrobe(cycleStrobe),
    .statusWrite(statusWrite));
  // =====================================================================
  // helpers
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // starts on a strobe edge: effects of the last take are caught half a clock later,
  // the claim flag just before the next strobe edge, where the task returns
  task automatic step(input logic [15:0] w, input logic v);
    instrValid <= v;
    instrWord <= w;
    @(negedge clk);
    cWr = memWr;
    cRd = memRd;
    cPc = pcCtl;
    cSt = stackCtl;
    cBusy = busy;
    cPtr = indirectPointerReg;
    repeat (3) @(posedge clk);
    @(negedge clk);
    cTaken = instrTaken;
    @(posedge clk);
  endtask
  task automatic loadPtr(input logic [1:0] s, input addr_t val);
    @(posedge clk);
    ptrLoad <= 1'b1;
    ptrLoadSel <= s;
    ptrLoadValue <= val;
    @(posedge clk);
    ptrLoad <= 1'b0;
    @(posedge clk iff cycleStrobe);
  endtask
  // =====================================================================
  // scenarios
  task automatic t_disabled();
    extendedSetEnable <= 1'b0;
    step(16'hFA08, 1'b1);
    chk("taken while disabled", 24'h0, 24'(cTaken));
    step(16'h0000, 1'b0);
    chk("write while disabled", 24'h0, 24'(cWr.en));
    extendedSetEnable <= 1'b1;
  endtask
  task automatic t_push();
    loadPtr(SEL_FRAME, 12'h1EC);
    step(16'hFA08, 1'b1);
    chk("push taken", 24'h1, 24'(cTaken));
    step(16'h0000, 1'b0);
    chk("push write", 24'h1, 24'(cWr.en));
    chk("push addr", 24'h1EC, 24'(cWr.addr));
    chk("push data", 24'h08, 24'(cWr.data));
    chk("push pointer", 24'h1EB, 24'(cPtr[2]));
  endtask
  task automatic t_sub();
    for (int s = 0; s < 3; s++)
    begin
      loadPtr(2'(s), 12'h3FF);
      step({8'hE9, 2'(s), 6'h23}, 1'b1);
      step(16'h0000, 1'b0);
      chk("sub pointer", 24'h3DC, 24'(cPtr[s]));
      chk("sub busy", 24'h0, 24'(cBusy));
    end
  endtask
  task automatic t_return();
    loadPtr(SEL_FRAME, 12'h3FF);
    returnStackTop <= 21'h0100AB;
    step(16'hE9E3, 1'b1);
    step(16'hFA08, 1'b1);
    chk("ret pointer", 24'h3DC, 24'(cPtr[2]));
    chk("ret other pointer", 24'h3DC, 24'(cPtr[1]));
    chk("ret pc load", 24'h1, 24'(cPc.load));
    chk("ret pc value", 24'h0100AB, 24'(cPc.value));
    chk("ret pop", 24'h1, 24'(cSt.pop));
    chk("ret busy", 24'h1, 24'(cBusy));
    chk("nop cycle taken", 24'h0, 24'(cTaken));
    step(16'h0000, 1'b0);
    chk("nop cycle write", 24'h0, 24'(cWr.en));
    chk("ret busy end", 24'h0, 24'(cBusy));
  endtask
  task automatic t_call();
    workingRegister <= 8'h06;
    pcHighLatch <= 8'h10;
    pcUpperLatch <= 5'h01;
    pcCurrent <= 21'h001234;
    step(OP_CALL_VIA_WORKING_REGISTER, 1'b1);
    step(16'h0000, 1'b0);
    chk("call pc load", 24'h1, 24'(cPc.load));
    chk("call pc value", 24'h011006, 24'(cPc.value));
    chk("call push", 24'h1, 24'(cSt.push));
    chk("call push value", 24'h001236, 24'(cSt.value));
    chk("call busy", 24'h1, 24'(cBusy));
  endtask
  // frame pointer, two words, expected read and write addresses, write expected, data
  task automatic t_move(input addr_t fp, input logic [15:0] w1, input logic [15:0] w2,
    input addr_t ra, input addr_t wa, input logic we, input logic [7:0] d);
    loadPtr(SEL_FRAME, fp);
    memRdData <= 8'h33;
    step(w1, 1'b1);
    step(w2, 1'b1);
    chk("move read", 24'h1, 24'(cRd.en));
    chk("move read addr", 24'(ra), 24'(cRd.addr));
    step(16'h0000, 1'b0);
    chk("move write", 24'(we), 24'(cWr.en));
    if (we)
    begin
      chk("move write addr", 24'(wa), 24'(cWr.addr));
      chk("move write data", 24'(d), 24'(cWr.data));
    end
  endtask
  // =====================================================================
  // clock, reset, run
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // sticky flag, cleared only while reset is held
  always @(negedge clk)
  begin
    if (!arst_n)
      statusBad = 1'b0;
    else if (statusWrite !== 1'b0)
      statusBad = 1'b1;
  end
  initial
  begin
    #300000;
    mismatches++;
    finish_test();
  end
  initial
  begin
    {arst_n, instrValid, ptrLoad, ptrLoadSel} = '0;
    {instrWord, workingRegister, pcHighLatch, pcUpperLatch, memRdData} = '0;
    {pcCurrent, returnStackTop, ptrLoadValue} = '0;
    extendedSetEnable = 1'b1;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk("reset pointer", 24'h0, 24'(indirectPointerReg[2]));
    chk("reset busy", 24'h0, 24'(busy));
    chk("reset strobe", 24'h0, 24'(cycleStrobe));
    @(posedge clk iff cycleStrobe);
    t_disabled();
    t_push();
    t_sub();
    t_return();
    t_call();
    // source wraps past the top, destination is the highest address
    // every move destination below but the indirect one is a plain data location, never pc or stack top
    t_move(12'hFFE, 16'hEB05, 16'hFFFF, 12'h003, 12'hFFF, 1'b1, 8'h33);
    // indexed form; don't-care bits of word two set to catch a wide decode
    t_move(12'h080, 16'hEB85, 16'hF3A6, 12'h085, 12'h0A6, 1'b1, 8'h33);
    // source on an indirect register reads as zero
    t_move(12'hFE0, 16'hEB8B, 16'hF381, 12'hFEB, 12'hFE1, 1'b1, 8'h00);
    // destination on an indirect register: nothing written
    t_move(12'hFE0, 16'hEB81, 16'hF38B, 12'hFE1, 12'hFEB, 1'b0, 8'h00);
    // second word without the 1111 tag: consumed, nothing written
    t_move(12'h080, 16'hEB05, 16'h1A06, 12'h085, 12'hA06, 1'b0, 8'h33);
    chk("status written", 24'h0, 24'(statusBad));
    finish_test();
  end
endmodule // tb
